// file: inc/cfsup_consts.vh
// Purpose: Constants for the converter fault supervisor.
// Assumes: 100 MHz hclk, AHB-Lite register access.
// Notes:   Times are in ns; cycle counts are derived in the design.
`ifndef CFSUP_CONSTS_VH
`define CFSUP_CONSTS_VH

// ---------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------
`define CFS_OFS_CTRL1    8'h00
`define CFS_OFS_CTRL3    8'h04
`define CFS_OFS_STATUS   8'h08

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define CFS_B_DISCH      0
`define CFS_B_RETRY_EN   1
`define CFS_B_BLANK      0
`define CFS_B_RETRY_FLG  0
`define CFS_B_CURRENT_LIMIT_FLAG_FLG   1
`define CFS_B_PG         2
`define CFS_B_INPUT_OVERVOLTAGE_LOCKOUT       3
`define CFS_B_SECOND     4
`define CFS_B_STATE      5

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define CFS_RST_CTRL1    2'h1
`define CFS_RST_CTRL3    1'h0

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CFS_CLK_NS       10
`define CFS_PAUSE_NS     128000
`define CFS_DEGL_NS      40000
`define CFS_RETRY_CNT    32
`define CFS_CURRENT_LIMIT_FLAG_CNT     4

`endif

// file: rtl/cfsup_top.v
// Purpose: Fault and power-good supervision for a step-down converter.
// Assumes: All analog comparator inputs are synchronous to hclk.
// Notes:   AHB-Lite slave, zero wait states, always OKAY.
//
// Operation
// - Input overvoltage stops switching and enables discharge when allowed.
// - Below the release threshold, switching resumes with a fresh soft start.
// - Over high-side limit: high side off, low side on, until below low limit.
// - Retry enable bit picks overload retry (1) or plain current limit (0).
// - Retry mode: 32 consecutive limited cycles halt switching 128 us, then restart.
// - Entering a retry pause sets the retry flag and, on a primary, holds power good low.
// - Limit count, pause and soft start repeat while the overload lasts.
// - Status read clears the retry flag only when overload is gone.
// - Limit mode sets the current limit flag after four consecutive limited cycles.
// - Status read clears the current limit flag only when overload is gone.
// - Output is out of window below 95% or above 105% of setpoint.
// - Window result is deglitched about 40 us, delaying power good rise.
// - With blanking set, the window result is ignored during a voltage ramp.
// - On a primary, power good is low in thermal shutdown, disabled, undervoltage, soft start.
// - A secondary sets both latches at initialization, pulling the line low.
// - A secondary clears its pull-down latch when its own soft start completes.
// - Line low until all finish soft start; then mode latch clears to continuous.
// - The discharge enable bit resets to enabled.

`include "cfsup_consts.vh"

module cfsup_top #(
  parameter PAUSE_CYC = (`CFS_PAUSE_NS + `CFS_CLK_NS - 1) / `CFS_CLK_NS
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg         hresp,
  output reg  [31:0] hrdata,
  input  wire        enable_in,
  input  wire        input_undervoltage_lockout_in,
  input  wire        thermal_shutdown_in,
  input  wire        vin_above_input_overvoltage_lockout,
  input  wire        vin_below_release,
  input  wire        cycle_start,
  input  wire        hs_over_limit,
  input  wire        ls_below_limit,
  input  wire        soft_start_done,
  input  wire        vout_below_window,
  input  wire        vout_above_window,
  input  wire        dynamic_voltage_ramp,
  input  wire        secondary_strap,
  input  wire        power_good_in,
  output reg         power_good_out,
  output reg         power_good_oe,
  output reg         switching_on,
  output reg         soft_start_run,
  output reg         hs_block,
  output reg         ls_force,
  output reg         discharge_on,
  output reg         discontinuous_conduction
);

  localparam DEGL_CYC = `CFS_DEGL_NS / `CFS_CLK_NS;

  localparam [2:0] ST_OFF   = 3'd0;
  localparam [2:0] ST_SOFT  = 3'd1;
  localparam [2:0] ST_RUN   = 3'd2;
  localparam [2:0] ST_PAUSE = 3'd3;
  localparam [2:0] ST_LOCK  = 3'd4;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  reg  [1:0]  ctrl1_q;
  reg  [1:0]  ctrl1_d;
  reg         ctrl3_q;
  reg         ctrl3_d;
  reg         retry_flg_q;
  reg         current_limit_flag_flg_q;
  reg         wr_pend_q;
  reg  [7:0]  wr_addr_q;
  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg  [5:0]  lim_cnt_q;
  reg         cyc_lim_q;
  reg  [15:0] pause_q;
  reg  [12:0] degl_q;
  reg         pg_good_q;
  reg         input_overvoltage_lockout_q;
  reg         second_q;
  reg         strap_done_q;
  reg         pd_latch_q;
  reg         mode_latch_q;

  wire        acc      = hsel & hready & htrans[1];
  wire        rd_stat  = acc & ~hwrite & (haddr == `CFS_OFS_STATUS);
  wire        go_cond  = enable_in & ~input_undervoltage_lockout_in & ~thermal_shutdown_in;
  wire        cyc_hit  = cyc_lim_q | hs_over_limit;
  wire        overload = (lim_cnt_q != 6'h00) | cyc_hit | (state_q == ST_PAUSE);
  wire        lim_full = (lim_cnt_q == `CFS_RETRY_CNT - 1) & cyc_hit & cycle_start;
  wire        lim_four = (lim_cnt_q >= `CFS_CURRENT_LIMIT_FLAG_CNT - 1) & cyc_hit & cycle_start;
  wire        retry_go = ctrl1_q[`CFS_B_RETRY_EN] & lim_full;
  wire        input_overvoltage_lockout_now = input_overvoltage_lockout_q | vin_above_input_overvoltage_lockout;

  // ---------------------------------------------------------------
  // Register writes, with next values used for read-after-write
  // ---------------------------------------------------------------
  always @* begin
    ctrl1_d = ctrl1_q;
    ctrl3_d = ctrl3_q;
    if (wr_pend_q && wr_addr_q == `CFS_OFS_CTRL1) begin
      ctrl1_d = hwdata[1:0];
    end
    if (wr_pend_q && wr_addr_q == `CFS_OFS_CTRL3) begin
      ctrl3_d = hwdata[`CFS_B_BLANK];
    end
  end

  function [31:0] rd_mux;
    input [7:0] a;
    input [1:0] c1;
    input       c3;
    begin
      case (a)
        `CFS_OFS_CTRL1:  rd_mux = {30'h0, c1};
        `CFS_OFS_CTRL3:  rd_mux = {31'h0, c3};
        `CFS_OFS_STATUS: rd_mux = {24'h0, state_q, second_q, input_overvoltage_lockout_q,
                                   pg_good_q, current_limit_flag_flg_q, retry_flg_q};
        default:         rd_mux = 32'h0;
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // AHB-Lite slave
  // ---------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      ctrl1_q   <= `CFS_RST_CTRL1;
      ctrl3_q   <= `CFS_RST_CTRL3;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      ctrl1_q   <= ctrl1_d;
      ctrl3_q   <= ctrl3_d;
      wr_pend_q <= acc & hwrite;
      if (acc) begin
        wr_addr_q <= haddr;
      end
      if (acc && !hwrite) begin
        hrdata <= rd_mux(haddr, ctrl1_d, ctrl3_d);
      end
    end
  end

  // ---------------------------------------------------------------
  // Status flags: a new event wins over a read that clears
  // ---------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      retry_flg_q <= 1'b0;
      current_limit_flag_flg_q  <= 1'b0;
    end else begin
      if (retry_go) begin
        retry_flg_q <= 1'b1;
      end else if (rd_stat && !overload) begin
        retry_flg_q <= 1'b0;
      end
      if (!ctrl1_q[`CFS_B_RETRY_EN] && lim_four) begin
        current_limit_flag_flg_q <= 1'b1;
      end else if (rd_stat && !overload) begin
        current_limit_flag_flg_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Current limit: block high side, count limited cycles
  // ---------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hs_block  <= 1'b0;
      ls_force  <= 1'b0;
      cyc_lim_q <= 1'b0;
      lim_cnt_q <= 6'h00;
    end else begin
      if (hs_over_limit) begin
        hs_block <= 1'b1;
        ls_force <= 1'b1;
      end else if (ls_below_limit) begin
        hs_block <= 1'b0;
        ls_force <= 1'b0;
      end
      if (cycle_start) begin
        cyc_lim_q <= 1'b0;
        if (!cyc_hit || retry_go || state_q != ST_RUN) begin
          lim_cnt_q <= 6'h00;
        end else if (lim_cnt_q != 6'h3f) begin
          lim_cnt_q <= lim_cnt_q + 6'h01;
        end
      end else if (hs_over_limit) begin
        cyc_lim_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Overvoltage lockout with hysteresis
  // ---------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      input_overvoltage_lockout_q <= 1'b0;
    end else if (vin_above_input_overvoltage_lockout) begin
      input_overvoltage_lockout_q <= 1'b1;
    end else if (vin_below_release) begin
      input_overvoltage_lockout_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Switching sequence
  // ---------------------------------------------------------------
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        if (input_overvoltage_lockout_now) begin
          state_d = ST_LOCK;
        end else if (go_cond) begin
          state_d = ST_SOFT;
        end
      end
      ST_SOFT, ST_RUN: begin
        if (input_overvoltage_lockout_now) begin
          state_d = ST_LOCK;
        end else if (!go_cond) begin
          state_d = ST_OFF;
        end else if (retry_go) begin
          state_d = ST_PAUSE;
        end else if (state_q == ST_SOFT && soft_start_done) begin
          state_d = ST_RUN;
        end
      end
      ST_PAUSE: begin
        if (input_overvoltage_lockout_now) begin
          state_d = ST_LOCK;
        end else if (!go_cond) begin
          state_d = ST_OFF;
        end else if (pause_q == 16'h0001) begin
          state_d = ST_SOFT;
        end
      end
      ST_LOCK: begin
        if (!input_overvoltage_lockout_now) begin
          state_d = go_cond ? ST_SOFT : ST_OFF;
        end
      end
      default: state_d = ST_OFF;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q        <= ST_OFF;
      pause_q        <= 16'h0000;
      switching_on   <= 1'b0;
      soft_start_run <= 1'b0;
      discharge_on   <= 1'b0;
    end else begin
      state_q <= state_d;
      if (state_q != ST_PAUSE && state_d == ST_PAUSE) begin
        pause_q <= PAUSE_CYC[15:0];
      end else if (pause_q != 16'h0000) begin
        pause_q <= pause_q - 16'h0001;
      end
      switching_on   <= (state_d == ST_SOFT) | (state_d == ST_RUN);
      soft_start_run <= (state_d == ST_SOFT);
      discharge_on   <= ctrl1_q[`CFS_B_DISCH] & ((state_d == ST_LOCK) | !go_cond);
    end
  end

  // ---------------------------------------------------------------
  // Power good: window, blanking, deglitch on the rising side
  // ---------------------------------------------------------------
  wire win_bad = vout_below_window | vout_above_window;
  wire win_use = win_bad & ~(ctrl3_q & dynamic_voltage_ramp);
  wire pg_kill = thermal_shutdown_in | !enable_in | input_undervoltage_lockout_in
               | (state_q != ST_RUN);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      degl_q    <= 13'h0000;
      pg_good_q <= 1'b0;
    end else if (win_use || pg_kill) begin
      degl_q    <= 13'h0000;
      pg_good_q <= 1'b0;
    end else if (degl_q >= DEGL_CYC - 1) begin
      pg_good_q <= 1'b1;
    end else begin
      degl_q <= degl_q + 13'h0001;
    end
  end

  // ---------------------------------------------------------------
  // Stack role and secondary latches
  // ---------------------------------------------------------------
  // Strap is sampled by a clocked process after reset release, never
  // by the reset itself, so the role is fixed until the next reset.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_done_q <= 1'b0;
      second_q     <= 1'b0;
      pd_latch_q   <= 1'b1;
      mode_latch_q <= 1'b1;
    end else begin
      strap_done_q <= 1'b1;
      if (!strap_done_q) begin
        second_q <= secondary_strap;
      end
      if (state_q == ST_SOFT && soft_start_done) begin
        pd_latch_q <= 1'b0;
      end
      if (!pd_latch_q && power_good_in) begin
        mode_latch_q <= 1'b0;
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power_good_out           <= 1'b0;
      power_good_oe            <= 1'b1;
      discontinuous_conduction <= 1'b1;
    end else begin
      power_good_out <= 1'b0;
      if (!strap_done_q || second_q) begin
        power_good_oe            <= pd_latch_q;
        discontinuous_conduction <= mode_latch_q;
      end else begin
        power_good_oe            <= !pg_good_q;
        discontinuous_conduction <= 1'b0;
      end
    end
  end

endmodule // cfsup_top

// file: testbench/cfsup_checker.sv
// Purpose: Port assertions for the converter fault supervisor.
// Assumes: One hclk domain, hresetn asynchronous active low.
// Notes:   Window and kill checks only hold for a primary device.
module cfsup_checker #(
  parameter PAUSE_CYC = 12800
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hs_over_limit,
  input wire logic ls_below_limit,
  input wire logic hs_block,
  input wire logic ls_force,
  input wire logic vin_above_input_overvoltage_lockout,
  input wire logic switching_on,
  input wire logic enable_in,
  input wire logic input_undervoltage_lockout_in,
  input wire logic thermal_shutdown_in,
  input wire logic vout_below_window,
  input wire logic vout_above_window,
  input wire logic dynamic_voltage_ramp,
  input wire logic secondary_strap,
  input wire logic soft_start_done,
  input wire logic power_good_in,
  input wire logic power_good_oe,
  input wire logic discontinuous_conduction
);
  logic [11:0] cln_q;
  wire logic kill = !enable_in || input_undervoltage_lockout_in || thermal_shutdown_in;
  wire logic win = vout_below_window || vout_above_window;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Ramps count as clean so the bound stays a safe lower limit
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      cln_q <= 12'h000;
    else if (kill || (win && !dynamic_voltage_ramp))
      cln_q <= 12'h000;
    else if (cln_q != 12'hfff)
      cln_q <= cln_q + 12'h001;
  end
  AST_HS_BLOCK: assert property (hs_over_limit |=> hs_block && ls_force)
    else $error("high side not blocked after overcurrent");
  AST_HS_HOLD: assert property (hs_block && !ls_below_limit |=> hs_block)
    else $error("high side released above low limit");
  AST_INPUT_OVERVOLTAGE_LOCKOUT: assert property (vin_above_input_overvoltage_lockout [*3] |-> !switching_on)
    else $error("switching during overvoltage");
  AST_PAUSE: assert property ($fell(switching_on) && !kill && !vin_above_input_overvoltage_lockout
    |-> !switching_on [*8]) else $error("retry pause too short");
  // Internal good bit falls on the next edge and the pin follows one edge later
  AST_PG_KILL: assert property (kill && !secondary_strap |-> ##2 power_good_oe)
    else $error("power good not low while killed");
  AST_PG_WIN: assert property (win && !dynamic_voltage_ramp && !secondary_strap
    |-> ##2 power_good_oe) else $error("power good not low out of window");
  AST_PG_DELAY: assert property ($fell(power_good_oe) && !secondary_strap
    |-> cln_q >= 12'hf3c) else $error("power good rose too early");
  AST_SEC_MODE: assert property (secondary_strap && $fell(discontinuous_conduction)
    |-> $past(power_good_in, 2)) else $error("mode latch cleared with line low");
  // A done pulse one edge back may already have cleared the latch
  AST_SEC_LATCH: assert property (secondary_strap && power_good_oe
    && !soft_start_done && !$past(soft_start_done) |=> power_good_oe)
    else $error("pull-down released before soft start done");
  cover property ($fell(switching_on));
  cover property ($fell(power_good_oe));
  cover property (secondary_strap && $fell(discontinuous_conduction));
endmodule // cfsup_checker

bind cfsup_top cfsup_checker #(.PAUSE_CYC(PAUSE_CYC)) u_chk (.hclk, .hresetn,
  .hs_over_limit, .ls_below_limit, .hs_block, .ls_force, .vin_above_input_overvoltage_lockout, .switching_on,
  .enable_in, .input_undervoltage_lockout_in, .thermal_shutdown_in, .vout_below_window, .vout_above_window,
  .dynamic_voltage_ramp, .secondary_strap, .soft_start_done, .power_good_in,
  .power_good_oe, .discontinuous_conduction);

// file: testbench/cfsup_partner.sv
// Purpose: Power stage and stacked neighbour seen by the supervisor.
// Assumes: Switching cycle of 8 hclk periods while switching is allowed.
// Notes:   Shared power good line has a pull-up.
module cfsup_partner (
  input  wire logic hclk,
  input  wire logic run,
  input  wire logic overload,
  input  wire logic dut_pull,
  input  wire logic other_pull,
  output logic      cycle_start = 1'b0,
  output logic      hs_over_limit = 1'b0,
  output logic      ls_below_limit = 1'b1,
  output wire logic power_good_in
);
  logic [2:0] ph_q = 3'h0;
  assign power_good_in = !(dut_pull || other_pull);
  always @(posedge hclk) begin
    ph_q <= ph_q + 3'h1;
    cycle_start <= run && ph_q == 3'h7;
    hs_over_limit <= run && overload && ph_q == 3'h2;
    ls_below_limit <= !overload || ph_q > 3'h4;
  end
endmodule // cfsup_partner

// file: testbench/cfsup_tb_top.sv
// Purpose: Self-checking bench for the converter fault supervisor.
// Assumes: AHB-Lite master tasks, retry pause shortened to 20 cycles.
// Notes:   Partner model makes the switching cycles.
`include "cfsup_consts.vh"
module cfsup_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic hclk = 0, hresetn = 0, hsel = 1, hwrite = 0, enable_in = 1, input_undervoltage_lockout_in = 0;
  logic thermal_shutdown_in = 0, vin_above_input_overvoltage_lockout = 0, vin_below_release = 1;
  logic soft_start_done = 1, vout_below_window = 0, vout_above_window = 0;
  logic dynamic_voltage_ramp = 0, secondary_strap = 0, overload = 0, other_pull = 0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [7:0]  haddr = 8'h00;
  logic [31:0] hwdata = 32'h0, hrdata, rdv;
  logic hreadyout, hresp, power_good_out, power_good_oe, switching_on, soft_start_run;
  logic hs_block, ls_force, discharge_on, discontinuous_conduction;
  wire logic cycle_start, hs_over_limit, ls_below_limit, power_good_in;
  int n_fail = 0, checks = 0;
  localparam logic [7:0] ST = `CFS_OFS_STATUS;

  cfsup_top #(.PAUSE_CYC(20)) u_dut (.hready(hreadyout), .*);
  cfsup_partner u_far (.hclk, .run(switching_on), .overload, .dut_pull(power_good_oe),
    .other_pull, .cycle_start, .hs_over_limit, .ls_below_limit, .power_good_in);

  always #5 hclk = ~hclk;

  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask
  task automatic rdc(logic [7:0] a, logic [31:0] m, logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("rd", rdv & m, e);
  endtask
  task automatic wt(int n);
    repeat (n) @(posedge hclk);
  endtask
  // Bounded so a stuck converter state cannot hang the run
  task automatic wsw(logic v);
    int i;
    i = 0;
    while (switching_on !== v && i < 3000) begin
      @(posedge hclk);
      i++;
    end
    chk("sw", switching_on, v);
  endtask
  task automatic complete_run();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    wt(10);
    hresetn <= 1'b1;
    rdc(`CFS_OFS_CTRL1, 32'hffffffff, 32'h1);
    rdc(`CFS_OFS_CTRL3, 32'hffffffff, 32'h0);
    rdc(8'h0c, 32'hffffffff, 32'h0);
    chk("resp", hresp, 0);
    wt(3900);
    chk("pg", power_good_oe, 1);
    wt(200);
    chk("pg", power_good_oe, 0);
    chk("pgo", power_good_out, 0);
    rdc(ST, 32'he4, 32'h44);
    bus(1'b1, `CFS_OFS_CTRL3, 32'h1);
    dynamic_voltage_ramp <= 1'b1;
    vout_above_window <= 1'b1;
    wt(5);
    chk("pg", power_good_oe, 0);
    dynamic_voltage_ramp <= 1'b0;
    wt(3);
    chk("pg", power_good_oe, 1);
    vout_above_window <= 1'b0;
    overload <= 1'b1;
    wt(60);
    rdc(ST, 32'h2, 32'h2);
    rdc(ST, 32'h2, 32'h2);
    overload <= 1'b0;
    wt(30);
    rdc(ST, 32'h2, 32'h2);
    rdc(ST, 32'h2, 32'h0);
    // Power good must be high again so the retry pause can pull it low
    wt(4000);
    chk("pg", power_good_oe, 0);
    bus(1'b1, `CFS_OFS_CTRL1, 32'h3);
    overload <= 1'b1;
    wsw(1'b0);
    rdc(ST, 32'he1, 32'h61);
    chk("pg", power_good_oe, 1);
    rdc(ST, 32'h1, 32'h1);
    wt(8);
    chk("sw", switching_on, 0);
    wsw(1'b1);
    wsw(1'b0);
    overload <= 1'b0;
    wsw(1'b1);
    wt(40);
    rdc(ST, 32'h1, 32'h1);
    rdc(ST, 32'h1, 32'h0);
    vin_above_input_overvoltage_lockout <= 1'b1;
    vin_below_release <= 1'b0;
    wt(4);
    chk("sw", switching_on, 0);
    chk("dis", discharge_on, 1);
    rdc(ST, 32'he8, 32'h88);
    vin_above_input_overvoltage_lockout <= 1'b0;
    wt(5);
    chk("sw", switching_on, 0);
    vin_below_release <= 1'b1;
    wsw(1'b1);
    // Let power good rise first so the shutdown check can see it fall
    wt(4100);
    chk("pg", power_good_oe, 0);
    thermal_shutdown_in <= 1'b1;
    wt(5);
    chk("pg", power_good_oe, 1);
    thermal_shutdown_in <= 1'b0;
    hresetn <= 1'b0;
    secondary_strap <= 1'b1;
    soft_start_done <= 1'b0;
    other_pull <= 1'b1;
    wt(10);
    hresetn <= 1'b1;
    wt(5);
    chk("oe", power_good_oe, 1);
    chk("mode", discontinuous_conduction, 1);
    chk("ss", soft_start_run, 1);
    soft_start_done <= 1'b1;
    wt(5);
    chk("oe", power_good_oe, 0);
    chk("ss", soft_start_run, 0);
    chk("mode", discontinuous_conduction, 1);
    other_pull <= 1'b0;
    wt(5);
    chk("mode", discontinuous_conduction, 0);
    complete_run();
  end

  initial begin
    #300us;
    n_fail++;
    complete_run();
  end
endmodule // cfsup_tb_top
